// [shared/byte_dma_consts.svh]
// Register offsets, field positions, reset values and counts of the byte DMA
`ifndef BYTE_DMA_CONSTS_SVH
`define BYTE_DMA_CONSTS_SVH
`define BD_OFS_CTRL 8'h00
`define BD_OFS_INTADDR 8'h04
`define BD_OFS_EXTADDR 8'h08
`define BD_OFS_PAGE 8'h0C
`define BD_OFS_COUNT 8'h10
`define BD_OFS_SYSCFG 8'h14
`define BD_OFS_STATUS 8'h18
`define BD_CTRL_FMT 0
`define BD_CTRL_DIR 2
`define BD_CTRL_CRH 3
`define BD_CTRL_PMOVL 4
`define BD_CTRL_DMOVL 8
`define BD_SYS_WAIT 0
`define BD_SYS_WMODE 4
`define BD_SYS_BSEL 5
`define BD_SYS_CSEL 6
`define BD_STAT_BUSY 0
`define BD_STAT_HALT 1
`define BD_BOOT_COUNT 14'h0020
`define BD_BSEL_RESET 1'b1
`define BD_SYNC_EXTRA 5'h02
`define BD_BOOT_DELAY 2'h3
`endif

// [shared/byte_dma_pkg.sv]
// Types shared by the byte DMA controller
package byte_dma_pkg;
  typedef enum logic [1:0] {
    FMT_PM24 = 2'h0,
    FMT_DM16 = 2'h1,
    FMT_DM8_HI = 2'h2,
    FMT_DM8_LO = 2'h3
  } format_e;
  typedef enum {
    S_IDLE,
    S_FETCH,
    S_LOAD,
    S_ARB,
    S_ACCESS,
    S_STORE,
    S_NEXT
  } state_e;
endpackage : byte_dma_pkg

// [logic/byte_memory_dma_controller.sv]
// Byte memory DMA controller with APB register slave
// Behaviour
// - 256 pages of 16K bytes, 4M total
// - Byte on D15-8, page on D23-16
// - Four-bit wait field plus mode bit
// - One core memory cycle per word
// - Two-bit format code selects word kind
// - Three, two or one bytes per word
// - Unused half of 8-bit formats zeroed
// - Start fields loaded before moving data
// - Nonzero count write starts byte accesses
// - Count decrements, zero stops and interrupts
// - External address carries across page boundaries
// - Internal end only on-chip memory
// - Full word moved in one cycle
// - Core external access wins the bus
// - Context-reset bit halts and restarts core
// - Overlay bits choose internal block
// - Byte select on at reset, composite routable
// - Boot loads defaults, 32 words, hold
//
// Implementation choices: the APB slave port and the address map.
`include "byte_dma_consts.svh"
module byte_memory_dma_controller
  import byte_dma_pkg::*;
#(
  parameter int unsigned AddrW = 14,
  parameter int unsigned PageW = 8
)(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bootFromByteMem,
  input wire logic coreExtReq,
  output logic memReq,
  output logic memWe,
  output logic memPm,
  output logic [AddrW-1:0] memAddr,
  output logic [23:0] memWdata,
  input wire logic [23:0] memRdata,
  output logic [3:0] pmOverlay,
  output logic [3:0] dmOverlay,
  output logic coreHalt,
  output logic coreRestart,
  output logic dmaDoneIrq,
  output logic [AddrW-1:0] busAddr,
  output logic [PageW-1:0] busPage,
  output logic [7:0] byteDataOut,
  output logic byteDataOe,
  input wire logic [7:0] byteDataIn,
  output logic byteRdN,
  output logic byteWrN,
  output logic byteSpaceSelN,
  output logic compositeSelN
);
  logic [1:0] rstSync_q;
  logic rstN;
  logic [1:0] bootSync_q;
  logic [7:0] dataSync1_q;
  logic [7:0] dataSync2_q;
  logic bootPend_q;
  logic [1:0] bootDly_q;
  logic bootGo;
  format_e transferFormat_q;
  logic transferDirection_q;
  logic contextResetHold_q;
  logic [3:0] byteWaitStates_q;
  logic waitMode_q;
  logic byteSelEnable_q;
  logic compositeFollow_q;
  state_e state_q;
  logic [AddrW-1:0] wordCount_q;
  logic [AddrW-1:0] internalStartAddress_q;
  logic [AddrW-1:0] externalStartAddress_q;
  logic [PageW-1:0] externalStartPage_q;
  logic [23:0] word_q;
  logic [1:0] byteIdx_q;
  logic [4:0] waitCnt_q;
  logic apbWr;
  logic idle;
  logic startGo;
  logic lastByte;
  logic [31:0] rdMux;
  logic rdHit;

  function automatic logic [3:0] waitCycles(input logic [3:0] w, input logic m);
    logic [4:0] d;
    d = {w, 1'b1};
    if (!m)
      return w;
    return (d > 5'h0F) ? 4'hF : d[3:0];
  endfunction : waitCycles

  function automatic logic [1:0] bytesPerWord(input format_e f);
    unique case (f)
      FMT_PM24: return 2'h3;
      FMT_DM16: return 2'h2;
      FMT_DM8_HI, FMT_DM8_LO: return 2'h1;
    endcase
  endfunction : bytesPerWord

  function automatic logic [7:0] byteOut(input format_e f, input logic [23:0] w, input logic [1:0] i);
    unique case (f)
      FMT_PM24: return (i == 2'h0) ? w[23:16] : ((i == 2'h1) ? w[15:8] : w[7:0]);
      FMT_DM16: return (i == 2'h0) ? w[15:8] : w[7:0];
      FMT_DM8_HI: return w[15:8];
      FMT_DM8_LO: return w[7:0];
    endcase
  endfunction : byteOut

  function automatic logic [23:0] packWord(input format_e f, input logic [23:0] w);
    unique case (f)
      FMT_PM24: return w;
      FMT_DM16: return {8'h00, w[15:0]};
      FMT_DM8_HI: return {8'h00, w[7:0], 8'h00};
      FMT_DM8_LO: return {16'h0000, w[7:0]};
    endcase
  endfunction : packWord

  // Blocks 1 and 2 are external overlays, never reachable from here
  function automatic logic [3:0] ovlFix(input logic [3:0] v);
    return (v == 4'h1 || v == 4'h2) ? 4'h0 : v;
  endfunction : ovlFix

  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      rstSync_q <= 2'h0;
    else
      rstSync_q <= {rstSync_q[0], 1'b1};
  assign rstN = rstSync_q[1];

  always_ff @(posedge sys_clk or negedge rstN)
    if (!rstN)
    begin
      bootSync_q <= 2'h0;
      dataSync1_q <= 8'h00;
      dataSync2_q <= 8'h00;
    end
    else
    begin
      bootSync_q <= {bootSync_q[0], bootFromByteMem};
      dataSync1_q <= byteDataIn;
      dataSync2_q <= dataSync1_q;
    end

  // Strap is read only once the synchroniser has settled
  always_ff @(posedge sys_clk or negedge rstN)
    if (!rstN)
    begin
      bootPend_q <= 1'b1;
      bootDly_q <= 2'h0;
    end
    else if (bootPend_q)
    begin
      bootDly_q <= bootDly_q + 2'h1;
      if (bootDly_q == `BD_BOOT_DELAY)
        bootPend_q <= 1'b0;
    end
  assign bootGo = bootPend_q && bootDly_q == `BD_BOOT_DELAY && bootSync_q[1];

  assign apbWr = psel && penable && pwrite;
  assign idle = state_q == S_IDLE;
  assign startGo = apbWr && paddr == `BD_OFS_COUNT && idle && pwdata[AddrW-1:0] != '0;
  assign lastByte = byteIdx_q == bytesPerWord(transferFormat_q) - 2'h1;

  always_comb
  begin
    rdMux = 32'h0000_0000;
    rdHit = 1'b1;
    case (paddr)
      `BD_OFS_CTRL: rdMux = {20'h0_0000, dmOverlay, pmOverlay, contextResetHold_q,
                             transferDirection_q, transferFormat_q};
      `BD_OFS_INTADDR: rdMux[AddrW-1:0] = internalStartAddress_q;
      `BD_OFS_EXTADDR: rdMux[AddrW-1:0] = externalStartAddress_q;
      `BD_OFS_PAGE: rdMux[PageW-1:0] = externalStartPage_q;
      `BD_OFS_COUNT: rdMux[AddrW-1:0] = wordCount_q;
      `BD_OFS_SYSCFG: rdMux[6:0] = {compositeFollow_q, byteSelEnable_q, waitMode_q, byteWaitStates_q};
      `BD_OFS_STATUS: rdMux[1:0] = {coreHalt, !idle};
      default: rdHit = 1'b0;
    endcase
  end

  // Zero-wait slave: answer is prepared in the setup cycle
  always_ff @(posedge sys_clk or negedge rstN)
    if (!rstN)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (psel && !penable)
      begin
        prdata <= pwrite ? 32'h0000_0000 : rdMux;
        pslverr <= !rdHit;
      end
    end

  always_ff @(posedge sys_clk or negedge rstN)
    if (!rstN)
    begin
      transferFormat_q <= FMT_PM24;
      transferDirection_q <= 1'b0;
      contextResetHold_q <= 1'b0;
      pmOverlay <= 4'h0;
      dmOverlay <= 4'h0;
      byteWaitStates_q <= 4'h0;
      waitMode_q <= 1'b0;
      byteSelEnable_q <= `BD_BSEL_RESET;
      compositeFollow_q <= 1'b0;
    end
    else if (bootGo)
    begin
      transferFormat_q <= FMT_PM24;
      transferDirection_q <= 1'b0;
      contextResetHold_q <= 1'b1;
    end
    else if (apbWr && paddr == `BD_OFS_CTRL)
    begin
      transferFormat_q <= format_e'(pwdata[`BD_CTRL_FMT +: 2]);
      transferDirection_q <= pwdata[`BD_CTRL_DIR];
      contextResetHold_q <= pwdata[`BD_CTRL_CRH];
      pmOverlay <= ovlFix(pwdata[`BD_CTRL_PMOVL +: 4]);
      dmOverlay <= ovlFix(pwdata[`BD_CTRL_DMOVL +: 4]);
    end
    else if (apbWr && paddr == `BD_OFS_SYSCFG)
    begin
      byteWaitStates_q <= pwdata[`BD_SYS_WAIT +: 4];
      waitMode_q <= pwdata[`BD_SYS_WMODE];
      byteSelEnable_q <= pwdata[`BD_SYS_BSEL];
      compositeFollow_q <= pwdata[`BD_SYS_CSEL];
    end

  always_ff @(posedge sys_clk or negedge rstN)
    if (!rstN)
    begin
      state_q <= S_IDLE;
      wordCount_q <= '0;
      internalStartAddress_q <= '0;
      externalStartAddress_q <= '0;
      externalStartPage_q <= '0;
      word_q <= 24'h00_0000;
      byteIdx_q <= 2'h0;
      waitCnt_q <= 5'h00;
      memReq <= 1'b0;
      memWe <= 1'b0;
      memPm <= 1'b0;
      memAddr <= '0;
      memWdata <= 24'h00_0000;
      busAddr <= '0;
      busPage <= '0;
      byteDataOut <= 8'h00;
      byteDataOe <= 1'b0;
      byteRdN <= 1'b1;
      byteWrN <= 1'b1;
      byteSpaceSelN <= 1'b1;
      compositeSelN <= 1'b1;
      coreHalt <= 1'b0;
      coreRestart <= 1'b0;
      dmaDoneIrq <= 1'b0;
    end
    else
    begin
      memReq <= 1'b0;
      coreRestart <= 1'b0;
      dmaDoneIrq <= 1'b0;
      if (bootGo || startGo)
      begin
        wordCount_q <= bootGo ? `BD_BOOT_COUNT : pwdata[AddrW-1:0];
        byteIdx_q <= 2'h0;
        coreHalt <= bootGo || contextResetHold_q;
        if (bootGo)
        begin
          internalStartAddress_q <= '0;
          externalStartAddress_q <= '0;
          externalStartPage_q <= '0;
        end
        if (!bootGo && transferDirection_q)
        begin
          memReq <= 1'b1;
          memWe <= 1'b0;
          memPm <= transferFormat_q == FMT_PM24;
          memAddr <= internalStartAddress_q;
          state_q <= S_FETCH;
        end
        else
          state_q <= S_ARB;
      end
      else if (idle && apbWr)
      begin
        if (paddr == `BD_OFS_INTADDR)
          internalStartAddress_q <= pwdata[AddrW-1:0];
        if (paddr == `BD_OFS_EXTADDR)
          externalStartAddress_q <= pwdata[AddrW-1:0];
        if (paddr == `BD_OFS_PAGE)
          externalStartPage_q <= pwdata[PageW-1:0];
      end
      else
      begin
        unique case (state_q)
          S_IDLE: ;
          S_FETCH: state_q <= S_LOAD;
          S_LOAD:
          begin
            word_q <= memRdata;
            state_q <= S_ARB;
          end
          S_ARB:
            if (!coreExtReq)
            begin
              busAddr <= externalStartAddress_q;
              busPage <= externalStartPage_q;
              byteDataOut <= byteOut(transferFormat_q, word_q, byteIdx_q);
              byteDataOe <= transferDirection_q;
              byteRdN <= transferDirection_q;
              byteWrN <= !transferDirection_q;
              byteSpaceSelN <= !byteSelEnable_q;
              compositeSelN <= !compositeFollow_q;
              waitCnt_q <= {1'b0, waitCycles(byteWaitStates_q, waitMode_q)} + `BD_SYNC_EXTRA;
              state_q <= S_ACCESS;
            end
          S_ACCESS:
            if (waitCnt_q != 5'h00)
              waitCnt_q <= waitCnt_q - 5'h01;
            else
            begin
              byteRdN <= 1'b1;
              byteWrN <= 1'b1;
              byteDataOe <= 1'b0;
              byteSpaceSelN <= 1'b1;
              compositeSelN <= 1'b1;
              {externalStartPage_q, externalStartAddress_q} <=
                {externalStartPage_q, externalStartAddress_q} + 22'h00_0001;
              byteIdx_q <= lastByte ? 2'h0 : byteIdx_q + 2'h1;
              if (!transferDirection_q)
                word_q <= {word_q[15:0], dataSync2_q};
              if (!lastByte)
                state_q <= S_ARB;
              else if (transferDirection_q)
                state_q <= S_NEXT;
              else
              begin
                memReq <= 1'b1;
                memWe <= 1'b1;
                memPm <= transferFormat_q == FMT_PM24;
                memAddr <= internalStartAddress_q;
                memWdata <= packWord(transferFormat_q, {word_q[15:0], dataSync2_q});
                state_q <= S_STORE;
              end
            end
          S_STORE: state_q <= S_NEXT;
          S_NEXT:
          begin
            wordCount_q <= wordCount_q - 1'b1;
            internalStartAddress_q <= internalStartAddress_q + 1'b1;
            if (wordCount_q == {{(AddrW-1){1'b0}}, 1'b1})
            begin
              dmaDoneIrq <= 1'b1;
              coreRestart <= coreHalt;
              coreHalt <= 1'b0;
              state_q <= S_IDLE;
            end
            else if (transferDirection_q)
            begin
              memReq <= 1'b1;
              memWe <= 1'b0;
              memAddr <= internalStartAddress_q + 1'b1;
              state_q <= S_FETCH;
            end
            else
              state_q <= S_ARB;
          end
        endcase
      end
    end

  logic [4:0] lowCnt_q;
  always_ff @(posedge sys_clk or negedge rstN)
    if (!rstN)
      lowCnt_q <= 5'h00;
    else
      lowCnt_q <= (byteRdN && byteWrN) ? 5'h00 : lowCnt_q + 5'h01;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstN);

  property p_priority;
    state_q == S_ARB && coreExtReq && !startGo |=> byteRdN && byteWrN;
  endproperty
  a_priority: assert property (p_priority) else $error("byte access started over core");
  property p_pageOnBus;
    !byteRdN || !byteWrN |-> busPage == externalStartPage_q && busAddr == externalStartAddress_q;
  endproperty
  a_pageOnBus: assert property (p_pageOnBus) else $error("page or address off bus");
  property p_zeroNoStart;
    apbWr && paddr == `BD_OFS_COUNT && idle && pwdata[AddrW-1:0] == '0 && !bootGo |=> idle && !dmaDoneIrq;
  endproperty
  a_zeroNoStart: assert property (p_zeroNoStart) else $error("zero count started");
  property p_startNonzero;
    startGo |=> !idle && wordCount_q == $past(pwdata[AddrW-1:0]);
  endproperty
  a_startNonzero: assert property (p_startNonzero) else $error("nonzero count did not start");
  property p_irqAtZero;
    dmaDoneIrq |-> wordCount_q == '0 && idle && $past(state_q == S_NEXT);
  endproperty
  a_irqAtZero: assert property (p_irqAtZero) else $error("interrupt without zero count");
  property p_oneCycleSteal;
    memReq |=> !memReq;
  endproperty
  a_oneCycleSteal: assert property (p_oneCycleSteal) else $error("more than one stolen cycle");
  property p_waitLen;
    $rose(byteRdN && byteWrN) |-> lowCnt_q == {1'b0, waitCycles(byteWaitStates_q, waitMode_q)} + 5'h03;
  endproperty
  a_waitLen: assert property (p_waitLen) else $error("strobe length wrong");
  property p_zeroFill;
    memReq && memWe && transferFormat_q == FMT_DM8_HI |-> memWdata[7:0] == 8'h00 && memWdata[23:16] == 8'h00;
  endproperty
  a_zeroFill: assert property (p_zeroFill) else $error("unused half not zero");
  property p_noExtOverlay;
    pmOverlay != 4'h1 && pmOverlay != 4'h2 && dmOverlay != 4'h1 && dmOverlay != 4'h2;
  endproperty
  a_noExtOverlay: assert property (p_noExtOverlay) else $error("external overlay selected");
  c_boot: cover property (bootGo ##[1:1000] dmaDoneIrq);
  c_writeDir: cover property (memReq && !memWe ##[1:100] !byteWrN);
  c_stall: cover property (state_q == S_ARB && coreExtReq ##1 state_q == S_ARB);
  c_restart: cover property (coreRestart);
endmodule : byte_memory_dma_controller

// [verif/byte_memory_model.sv]
// Byte-wide external memory model for the byte DMA bench
module byte_memory_model(
  input wire logic sys_clk,
  input wire logic [13:0] busAddr,
  input wire logic [7:0] busPage,
  input wire logic [7:0] byteDataOut,
  input wire logic byteDataOe,
  input wire logic byteRdN,
  input wire logic byteWrN,
  input wire logic byteSpaceSelN,
  input wire logic compositeSelN,
  input wire logic [3:0] latency,
  output logic [7:0] byteDataIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [logic [21:0]];
  int rdAge = 0;
  logic sel;
  // Either select reaches the part
  assign sel = !byteSpaceSelN || !compositeSelN;
  function automatic logic [7:0] rd(input logic [21:0] a);
    return mem.exists(a) ? mem[a] : a[7:0] ^ a[21:14];
  endfunction : rd
  initial byteDataIn = 8'h00;
  // Page lines above the 14 address lines
  // Full address always seen here, no host-mode glue needed
  always @(posedge sys_clk)
    if (sel && !byteWrN && byteDataOe)
      mem[{busPage, busAddr}] = byteDataOut;
  // Answers off the sampling edge, like an asynchronous part
  always @(negedge sys_clk)
  begin
    rdAge <= (sel && !byteRdN) ? rdAge + 1 : 0;
    // Slow part: released lines toggle, never a stale byte
    if (sel && !byteRdN && rdAge >= latency)
      byteDataIn <= rd({busPage, busAddr});
    else
      byteDataIn <= ~byteDataIn;
  end
endmodule : byte_memory_model

// [verif/testbench.sv]
// Self-checking bench for the byte memory DMA controller
`include "byte_dma_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import byte_dma_pkg::*;
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic bootFromByteMem, coreExtReq, memReq, memWe, memPm, coreHalt, coreRestart, dmaDoneIrq;
  logic byteDataOe, byteRdN, byteWrN, byteSpaceSelN, compositeSelN;
  logic [7:0] paddr, busPage, byteDataOut, byteDataIn;
  logic [31:0] pwdata, prdata, rdat;
  logic [13:0] memAddr, busAddr;
  logic [23:0] memWdata, memRdata;
  logic [3:0] pmOverlay, dmOverlay, latency;
  logic [23:0] wq [$];
  logic pq [$];
  int errors = 0, testsRun = 0, irqCnt = 0, rstCnt = 0, strobeCnt = 0, lowCnt = 0, lastLow = 0;
  int bsLow = 0, haltSeen = 0;
  byte_memory_dma_controller byte_memory_dma_controller_inst (.sys_clk, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bootFromByteMem, .coreExtReq, .memReq,
    .memWe, .memPm, .memAddr, .memWdata, .memRdata, .pmOverlay, .dmOverlay, .coreHalt, .coreRestart,
    .dmaDoneIrq, .busAddr, .busPage, .byteDataOut, .byteDataOe, .byteDataIn, .byteRdN, .byteWrN,
    .byteSpaceSelN, .compositeSelN);
  byte_memory_model byte_memory_model_inst (.sys_clk, .busAddr, .busPage, .byteDataOut, .byteDataOe,
    .byteRdN, .byteWrN, .byteSpaceSelN, .compositeSelN, .latency, .byteDataIn);
  function automatic logic [23:0] rom(input logic [13:0] a);
    return {a[7:0] ^ 8'hA5, a[7:0], ~a[7:0]};
  endfunction : rom
  function automatic logic [7:0] b(input logic [21:0] x);
    return byte_memory_model_inst.rd(x);
  endfunction : b
  // On-chip memory side and event counters
  always @(posedge sys_clk)
  begin
    memRdata <= (memReq && !memWe) ? rom(memAddr) : ~memRdata;
    if (memReq && memWe)
    begin
      wq.push_back(memWdata);
      pq.push_back(memPm);
    end
    irqCnt += dmaDoneIrq;
    rstCnt += coreRestart;
    bsLow += !byteSpaceSelN;
    haltSeen += coreHalt;
    if (!byteRdN || !byteWrN)
      lowCnt++;
    else if (lowCnt != 0)
    begin
      lastLow = lowCnt;
      lowCnt = 0;
      strobeCnt++;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rdat);
  endtask : rchk
  task automatic waitDone(input int n0);
    int k;
    k = 0;
    while (irqCnt == n0 && k < 20000)
    begin
      @(posedge sys_clk);
      k++;
    end
    chk("done pulse", n0 + 1, irqCnt);
  endtask : waitDone
  // Start fields, then count; address and page left alone while busy
  task automatic xfer(input logic [31:0] ctl, input logic [13:0] ia, input logic [21:0] ea, input logic [13:0] n);
    int n0;
    apb(1'b1, `BD_OFS_CTRL, ctl);
    apb(1'b1, `BD_OFS_INTADDR, 32'(ia));
    apb(1'b1, `BD_OFS_EXTADDR, 32'(ea[13:0]));
    apb(1'b1, `BD_OFS_PAGE, 32'(ea[21:14]));
    n0 = irqCnt;
    wq.delete();
    pq.delete();
    apb(1'b1, `BD_OFS_COUNT, 32'(n));
    waitDone(n0);
  endtask : xfer
  task automatic s_regs;
    rchk("syscfg reset", `BD_OFS_SYSCFG, 32'h0000_0020);
    rchk("status reset", `BD_OFS_STATUS, 32'h0000_0000);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, 32'(rerr));
    apb(1'b1, `BD_OFS_CTRL, 32'h0000_0210);
    rchk("external overlay", `BD_OFS_CTRL, 32'h0000_0000);
    apb(1'b1, `BD_OFS_CTRL, 32'h0000_0540);
    rchk("internal overlay", `BD_OFS_CTRL, 32'h0000_0540);
    chk("pm overlay", 32'h0000_0004, 32'(pmOverlay));
    chk("dm overlay", 32'h0000_0005, 32'(dmOverlay));
  endtask : s_regs
  task automatic s_page;
    apb(1'b1, `BD_OFS_SYSCFG, 32'h0000_0024);
    latency <= 4'h3;
    xfer(32'h0000_0001, 14'h0040, 22'h01_7FFE, 14'h0002);
    chk("words", 32'h0000_0002, 32'(wq.size()));
    chk("word 0", {8'h00, b(22'h01_7FFE), b(22'h01_7FFF), 8'h00} >> 8, 32'(wq[0]));
    chk("word 1", {16'h0000, b(22'h01_8000), b(22'h01_8001)}, 32'(wq[1]));
    chk("wait mode 0", 32'h0000_0007, 32'(lastLow));
    rchk("count left", `BD_OFS_COUNT, 32'h0000_0000);
    rchk("page carried", `BD_OFS_PAGE, 32'h0000_0006);
  endtask : s_page
  task automatic s_fmt;
    logic [23:0] exp;
    int b0, h0;
    apb(1'b1, `BD_OFS_SYSCFG, 32'h0000_0054);
    b0 = bsLow;
    h0 = haltSeen;
    for (int f = 0; f < 4; f++)
    begin
      xfer(32'(f), 14'h0010, 22'h00_0100, 14'h0001);
      case (f)
        0: exp = {b(22'h00_0100), b(22'h00_0101), b(22'h00_0102)};
        1: exp = {8'h00, b(22'h00_0100), b(22'h00_0101)};
        2: exp = {8'h00, b(22'h00_0100), 8'h00};
        default: exp = {16'h0000, b(22'h00_0100)};
      endcase
      chk("format word", 32'(exp), 32'(wq[0]));
      chk("program space", 32'(f == 0), 32'(pq[0]));
      chk("wait mode 1", 32'h0000_000C, 32'(lastLow));
    end
    chk("byte select off", 32'(b0), 32'(bsLow));
    chk("core runs", 32'(h0), 32'(haltSeen));
  endtask : s_fmt
  task automatic s_write;
    int h0, r0;
    logic [47:0] w;
    apb(1'b1, `BD_OFS_SYSCFG, 32'h0000_0020);
    h0 = haltSeen;
    r0 = rstCnt;
    xfer(32'h0000_000C, 14'h0020, 22'h00_C200, 14'h0002);
    chk("core held", 32'h0000_0001, 32'(haltSeen > h0));
    chk("restart pulse", 32'(r0 + 1), 32'(rstCnt));
    w = {rom(14'h0020), rom(14'h0021)};
    for (int i = 0; i < 6; i++)
      chk("byte written", 32'(w[47 - 8 * i -: 8]), 32'(b(22'h00_C200 + 22'(i))));
  endtask : s_write
  task automatic s_zero_arb;
    int n0, s0;
    n0 = irqCnt;
    s0 = strobeCnt;
    apb(1'b1, `BD_OFS_COUNT, 32'h0000_0000);
    repeat (20) @(posedge sys_clk);
    rchk("status idle", `BD_OFS_STATUS, 32'h0000_0000);
    chk("no done pulse", 32'(n0), 32'(irqCnt));
    chk("no strobe", 32'(s0), 32'(strobeCnt));
    coreExtReq <= 1'b1;
    apb(1'b1, `BD_OFS_CTRL, 32'h0000_0003);
    apb(1'b1, `BD_OFS_COUNT, 32'h0000_0001);
    repeat (30) @(posedge sys_clk);
    chk("core bus first", 32'(s0), 32'(strobeCnt + lowCnt));
    rchk("busy while held off", `BD_OFS_STATUS, 32'h0000_0001);
    coreExtReq <= 1'b0;
    waitDone(n0);
  endtask : s_zero_arb
  task automatic s_boot;
    int n0, r0;
    latency <= 4'h0;
    bootFromByteMem <= 1'b1;
    resetn <= 1'b0;
    n0 = irqCnt;
    r0 = rstCnt;
    repeat (4) @(posedge sys_clk);
    wq.delete();
    pq.delete();
    resetn <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk("boot holds core", 32'h0000_0001, 32'(coreHalt));
    waitDone(n0);
    chk("boot words", 32'h0000_0020, 32'(wq.size()));
    chk("boot word 0", 32'({b(22'h00_0000), b(22'h00_0001), b(22'h00_0002)}), 32'(wq[0]));
    chk("boot program", 32'h0000_0001, 32'(pq[31]));
    chk("boot restart", 32'(r0 + 1), 32'(rstCnt));
  endtask : s_boot
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", testsRun, errors);
    if (errors == 0 && testsRun > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    bootFromByteMem = 1'b0;
    coreExtReq = 1'b0;
    latency = 4'h0;
    memRdata = 24'h00_0000;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    s_regs();
    s_page();
    s_fmt();
    s_write();
    s_zero_arb();
    s_boot();
    complete_run();
  end
  // Whole run needs under two thousand cycles
  initial
  begin
    #200000;
    errors++;
    complete_run();
  end
endmodule : testbench
